//--- burst_sram_port.v
// Pipelined burst SRAM port with no bus turnaround: core, pipeline, sleep
//
// Functional notes
// - Clock qualifier high freezes command, pipeline and output data for that edge; sleep and output enable still run.
// - Load with all selects active and write strobe high starts a read.
// - Read word leaves the output register one edge after the command.
// - Any new command may follow a read on the very next edge.
// - Load with a select inactive tri-states outputs after the next edge.
// - Burst counter lets one address serve four accesses, then wraps round them again.
// - Order strap picks linear or interleaved; two low bits wrap.
// - Advance steps the counter, ignoring selects and write strobe.
// - Write strobe taken only at load; type kept for the burst.
// - Load with all selects active and write strobe low starts a write.
// - Edge after a write command tri-states data and parity lines.
// - Second edge after a write command captures host data and parity.
// - Only lanes with active byte-write enable change, parity included.
// - Sleep input enters and leaves sleep in two cycles, contents kept.
// - Accesses pending at sleep entry are dropped.
// - Interleaved beat bits are start bits XOR beat count.
// - Linear beat bits are start bits plus beat count, modulo four.
// - Beat with all byte enables high writes nothing, lines undriven.
// - From reset the port is deselected with lines undriven.
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_consts.vh"

module burst_sram_port #(
	parameter LANES  = `DEF_LANES,
	parameter ADDR_W = `DEF_ADDR_W
) (
	input  wire                               sys_clk,
	input  wire                               resetn,
	input  wire                               clock_qualify_n,
	input  wire                               chip_select_1_n,
	input  wire                               chip_select_2,
	input  wire                               chip_select_3_n,
	input  wire                               advance_or_load,
	input  wire                               write_enable_n,
	input  wire [LANES-1:0]                   byte_lane_write_n,
	input  wire [ADDR_W-1:0]                  address,
	input  wire                               output_drive_enable_n,
	input  wire                               sleep_request,
	input  wire                               burst_order_select,
	input  wire [LANES*`LANE_DATA_BITS-1:0]   data_in,
	input  wire [LANES-1:0]                   parity_in,
	output wire [LANES*`LANE_DATA_BITS-1:0]   data_out,
	output wire                               data_oe_n,
	output wire [LANES-1:0]                   shared_parity_lines_out,
	output wire                               shared_parity_lines_oe_n,
	output wire                               sleep_active
);

	localparam DW    = LANES * `LANE_DATA_BITS;
	localparam WORDW = LANES * `LANE_BITS;
	localparam DEPTH = 1 << ADDR_W;
	localparam [1:0] SLP_AWAKE  = 2'b00;
	localparam [1:0] SLP_ENTER  = 2'b01;
	localparam [1:0] SLP_ASLEEP = 2'b10;
	localparam [1:0] SLP_EXIT   = 2'b11;
	localparam [`SLEEP_CNT_W-1:0] ENTER_LAST = `SLEEP_ENTER_CYC - 2'h1;
	localparam [`SLEEP_CNT_W-1:0] EXIT_LAST  = `SLEEP_EXIT_CYC - 2'h1;

	// ----------------------------------------
	// Asynchronous pins
	// ----------------------------------------
	wire                   oe_pin_n_s;
	wire                   sleep_s;
	wire                   interleave_s;

	sync_2ff #(
		.WIDTH (3),
		.INIT  ({`DRIVE_OFF_N, 1'b0, `BURST_ORDER_INIT})
	) u_pin_sync (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.pin_async ({output_drive_enable_n, sleep_request, burst_order_select}),
		.pin_sync  ({oe_pin_n_s, sleep_s, interleave_s})
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [1:0]                 slp_state_q;
	reg  [1:0]                 slp_state_d;
	reg  [`SLEEP_CNT_W-1:0]    slp_cnt_q;
	reg  [`SLEEP_CNT_W-1:0]    slp_cnt_d;
	reg                        sleep_active_q;
	reg                        burst_act_q;
	reg                        burst_read_q;
	reg  [ADDR_W-1:0]          burst_base_q;
	reg  [`BURST_CNT_W-1:0]    burst_cnt_q;
	reg                        s1_valid_q;
	reg                        s1_read_q;
	reg  [ADDR_W-1:0]          s1_addr_q;
	reg  [LANES-1:0]           s1_bw_n_q;
	reg                        s2_valid_q;
	reg  [ADDR_W-1:0]          s2_addr_q;
	reg  [LANES-1:0]           s2_bw_n_q;
	reg  [DW-1:0]              data_out_q;
	reg  [LANES-1:0]           parity_out_q;
	reg                        drive_n_q;
	reg                        rd_valid_q;
	reg  [WORDW-1:0]           mem [0:DEPTH-1];

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire awake    = (slp_state_q == SLP_AWAKE);
	wire run      = !clock_qualify_n;
	wire cmd_en   = run && awake;
	wire all_sel  = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	wire do_load  = cmd_en && !advance_or_load;
	wire do_adv   = cmd_en && advance_or_load;
	wire [`BURST_CNT_W-1:0] next_cnt = burst_cnt_q + 1'b1;
	wire [`BURST_CNT_W-1:0] beat_bits;
	burst_seq u_burst_seq (
		.start_bits (burst_base_q[`BURST_CNT_W-1:0]),
		.beat       (next_cnt),
		.interleave (interleave_s),
		.beat_bits  (beat_bits)
	);
	wire [ADDR_W-1:0] beat_addr = {burst_base_q[ADDR_W-1:`BURST_CNT_W], beat_bits};

	// ----------------------------------------
	// Sleep sequencer
	// ----------------------------------------
	always @*
	begin
		slp_state_d = slp_state_q;
		slp_cnt_d   = slp_cnt_q;
		case (slp_state_q)
			SLP_AWAKE:   // Count is left at zero by ENTER and EXIT
				if (sleep_s)
					slp_state_d = SLP_ENTER;
			SLP_ENTER:
			begin
				slp_cnt_d = slp_cnt_q + 1'b1;
				if (slp_cnt_q == ENTER_LAST)
				begin
					slp_state_d = SLP_ASLEEP;
					slp_cnt_d   = {`SLEEP_CNT_W{1'b0}};
				end
			end
			SLP_ASLEEP:
				if (!sleep_s)
					slp_state_d = SLP_EXIT;
			SLP_EXIT:
			begin
				slp_cnt_d = slp_cnt_q + 1'b1;
				if (slp_cnt_q == EXIT_LAST)
				begin
					slp_state_d = SLP_AWAKE;
					slp_cnt_d   = {`SLEEP_CNT_W{1'b0}};
				end
			end
			default:
			begin
				slp_state_d = SLP_AWAKE;
				slp_cnt_d   = {`SLEEP_CNT_W{1'b0}};
			end
		endcase
	end

	// Sleep is asynchronous to the qualifier, so it runs on every edge
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			slp_state_q    <= SLP_AWAKE;
			slp_cnt_q      <= {`SLEEP_CNT_W{1'b0}};
			sleep_active_q <= 1'b0;
		end
		else
		begin
			slp_state_q    <= slp_state_d;
			slp_cnt_q      <= slp_cnt_d;
			sleep_active_q <= (slp_state_d != SLP_AWAKE);
		end
	end

	// ----------------------------------------
	// Burst counter and command stage
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			burst_act_q  <= 1'b0;
			burst_read_q <= 1'b1;
			burst_base_q <= {ADDR_W{1'b0}};
			burst_cnt_q  <= {`BURST_CNT_W{1'b0}};
			s1_valid_q   <= 1'b0;
			s1_read_q    <= 1'b1;
			s1_addr_q    <= {ADDR_W{1'b0}};
			s1_bw_n_q    <= {LANES{1'b1}};
		end
		else if (!awake)
		begin
			burst_act_q <= 1'b0;
			s1_valid_q  <= 1'b0;
		end
		else if (do_load)
		begin
			burst_act_q  <= all_sel;
			s1_valid_q   <= all_sel;
			if (all_sel)
			begin
				burst_read_q <= write_enable_n;
				burst_base_q <= address;
				burst_cnt_q  <= {`BURST_CNT_W{1'b0}};
				s1_read_q    <= write_enable_n;
				s1_addr_q    <= address;
				s1_bw_n_q    <= byte_lane_write_n;
			end
		end
		else if (do_adv)
		begin
			// Selects and write strobe are not looked at here
			s1_valid_q <= burst_act_q;
			if (burst_act_q)
			begin
				burst_cnt_q <= next_cnt;
				s1_read_q   <= burst_read_q;
				s1_addr_q   <= beat_addr;
				s1_bw_n_q   <= byte_lane_write_n;
			end
		end
	end

	// ----------------------------------------
	// Write data stage
	// ----------------------------------------
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s2_valid_q <= 1'b0;
			s2_addr_q  <= {ADDR_W{1'b0}};
			s2_bw_n_q  <= {LANES{1'b1}};
		end
		else if (!awake)
			s2_valid_q <= 1'b0;
		else if (run)
		begin
			s2_valid_q <= s1_valid_q && !s1_read_q;
			s2_addr_q  <= s1_addr_q;
			s2_bw_n_q  <= s1_bw_n_q;
		end
	end

	// ----------------------------------------
	// Core array
	// ----------------------------------------
	wire do_write = run && awake && s2_valid_q;
	integer wl;
	always @(posedge sys_clk)
	begin
		if (do_write)
		begin
			for (wl = 0; wl < LANES; wl = wl + 1)
			begin
				// All enables high is a write abort
				if (!s2_bw_n_q[wl])
					mem[s2_addr_q][wl*`LANE_BITS +: `LANE_BITS] <=
						{parity_in[wl], data_in[wl*`LANE_DATA_BITS +: `LANE_DATA_BITS]};
			end
		end
	end

	// ----------------------------------------
	// Read path with write forwarding
	// ----------------------------------------
	// A write retiring on this edge must be seen by a read of the same word
	reg [WORDW-1:0] rd_word;
	reg [DW-1:0]    rd_data;
	reg [LANES-1:0] rd_par;
	integer         rl;
	always @*
	begin
		rd_word = mem[s1_addr_q];
		rd_data = {DW{1'b0}};
		rd_par  = {LANES{1'b0}};
		for (rl = 0; rl < LANES; rl = rl + 1)
		begin
			if (do_write && (s2_addr_q == s1_addr_q) && !s2_bw_n_q[rl])
				rd_word[rl*`LANE_BITS +: `LANE_BITS] =
					{parity_in[rl], data_in[rl*`LANE_DATA_BITS +: `LANE_DATA_BITS]};
			rd_data[rl*`LANE_DATA_BITS +: `LANE_DATA_BITS] =
				rd_word[rl*`LANE_BITS +: `LANE_DATA_BITS];
			rd_par[rl] = rd_word[rl*`LANE_BITS + `LANE_DATA_BITS];
		end
	end

	// Read valid held through a stall; dropped by sleep
	wire rd_valid_d = !awake ? 1'b0 : (run ? (s1_valid_q && s1_read_q) : rd_valid_q);

	// ----------------------------------------
	// Output register and drivers
	// ----------------------------------------
	// Enable tracks the pin on every edge, even in a stall, so the host
	// can always turn the bus around; the data itself holds
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			data_out_q   <= {DW{1'b0}};
			parity_out_q <= {LANES{1'b0}};
			rd_valid_q   <= 1'b0;
			drive_n_q    <= `DRIVE_OFF_N;
		end
		else
		begin
			rd_valid_q <= rd_valid_d;
			if (run && awake && s1_valid_q && s1_read_q)
			begin
				data_out_q   <= rd_data;
				parity_out_q <= rd_par;
			end
			// Write, deselect, sleep and dummy read all leave it off
			drive_n_q <= !(rd_valid_d && !oe_pin_n_s);
		end
	end

	assign data_out                 = data_out_q;
	assign shared_parity_lines_out  = parity_out_q;
	assign data_oe_n                = drive_n_q;
	assign shared_parity_lines_oe_n = drive_n_q;
	assign sleep_active             = sleep_active_q;

endmodule // burst_sram_port

`default_nettype wire

//--- burst_sram_consts.vh
// Shared constants for the pipelined burst SRAM port
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define LANE_DATA_BITS   8
`define LANE_BITS        9
`define DEF_LANES        4
`define DEF_ADDR_W       19
`define BURST_CNT_W      2

// ----------------------------------------
// Sleep timing, in clock cycles
// ----------------------------------------
`define SLEEP_ENTER_CYC  2'h2
`define SLEEP_EXIT_CYC   2'h2
`define SLEEP_CNT_W      2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DRIVE_OFF_N      1'b1
`define BURST_ORDER_INIT 1'b1

`endif

//--- sync_2ff.v
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
	parameter       WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input  wire             sys_clk,
	input  wire             resetn,
	input  wire [WIDTH-1:0] pin_async,
	output wire [WIDTH-1:0] pin_sync
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
		end
		else
		begin
			meta_q <= pin_async;
			sync_q <= meta_q;
		end
	end

	assign pin_sync = sync_q;

endmodule // sync_2ff

`default_nettype wire

//--- burst_seq.v
// Burst beat low-address generator, linear or interleaved order
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_consts.vh"

module burst_seq (
	input  wire [`BURST_CNT_W-1:0] start_bits,
	input  wire [`BURST_CNT_W-1:0] beat,
	input  wire                    interleave,
	output reg  [`BURST_CNT_W-1:0] beat_bits
);

	always @*
	begin
		if (interleave)
			beat_bits = start_bits ^ beat;
		else
			beat_bits = start_bits + beat;
	end

endmodule // burst_seq

`default_nettype wire

//--- burst_sram_port_checker.sv
// Pin-level assertions for the pipelined burst SRAM port
`timescale 1ns/10ps
`default_nettype none
`include "burst_sram_consts.vh"

module burst_sram_port_checker #(
	parameter LANES = `DEF_LANES
) (
	input wire                             sys_clk,
	input wire                             resetn,
	input wire                             clock_qualify_n,
	input wire                             chip_select_1_n,
	input wire                             chip_select_2,
	input wire                             chip_select_3_n,
	input wire                             advance_or_load,
	input wire                             write_enable_n,
	input wire                             output_drive_enable_n,
	input wire                             sleep_request,
	input wire [LANES*`LANE_DATA_BITS-1:0] data_out,
	input wire                             data_oe_n,
	input wire [LANES-1:0]                 shared_parity_lines_out,
	input wire                             shared_parity_lines_oe_n,
	input wire                             sleep_active
);
	// ----------------------------------------
	// Decoded commands
	// ----------------------------------------
	wire sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
	wire go  = !clock_qualify_n && !advance_or_load && !sleep_active && !sleep_request;
	wire rd  = go && sel && write_enable_n;
	wire wr  = go && sel && !write_enable_n;
	wire ds  = go && !sel;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_reset_quiet: assert property ($rose(resetn) |-> data_oe_n && !sleep_active)
		else $error("outputs driven right after reset");
	a_lanes_paired: assert property (data_oe_n == shared_parity_lines_oe_n)
		else $error("data and parity drive differ");
	a_write_undriven: assert property (wr ##1 !clock_qualify_n |=> data_oe_n)
		else $error("lines driven after write command");
	a_deselect_undriven: assert property (ds ##1 !clock_qualify_n |=> data_oe_n)
		else $error("lines driven after deselect");
	a_read_drives: assert property (rd && $past(resetn, 3) && !output_drive_enable_n
		&& !$past(output_drive_enable_n) && !$past(output_drive_enable_n, 2)
		##1 (!clock_qualify_n && !output_drive_enable_n) |=> !data_oe_n)
		else $error("read word not driven");
	a_dummy_read: assert property (rd && output_drive_enable_n
		&& $past(output_drive_enable_n) ##1 output_drive_enable_n |=> data_oe_n)
		else $error("dummy read drove lines");
	a_stall_holds: assert property (clock_qualify_n |=>
		$stable(data_out) && $stable(shared_parity_lines_out))
		else $error("output register moved on stalled edge");
	a_sleep_quiet: assert property (sleep_active && $past(sleep_active) |-> data_oe_n)
		else $error("lines driven in sleep");
	a_sleep_enter: assert property ($rose(sleep_request) |-> ##[1:6] sleep_active)
		else $error("sleep not entered in time");
	a_sleep_exit: assert property ($fell(sleep_request) |-> ##[1:8] !sleep_active)
		else $error("sleep not left in time");

	c_read: cover property (rd ##2 !data_oe_n);
	c_write: cover property (wr);
	c_stall: cover property (clock_qualify_n);
	c_sleep: cover property ($rose(sleep_active));
endmodule // burst_sram_port_checker

bind burst_sram_port burst_sram_port_checker #(.LANES(LANES)) chk (.sys_clk, .resetn,
	.clock_qualify_n, .chip_select_1_n, .chip_select_2, .chip_select_3_n, .advance_or_load,
	.write_enable_n, .output_drive_enable_n, .sleep_request, .data_out, .data_oe_n,
	.shared_parity_lines_out, .shared_parity_lines_oe_n, .sleep_active);
`default_nettype wire

//--- host_bus_model.sv
// Host memory controller model driving the synchronous SRAM bus
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
	input  wire logic        sys_clk,
	input  wire logic [31:0] data_out,
	input  wire logic        data_oe_n,
	input  wire logic [3:0]  shared_parity_lines_out,
	output var  logic        clock_qualify_n,
	output var  logic        chip_select_1_n,
	output var  logic        chip_select_2,
	output var  logic        chip_select_3_n,
	output var  logic        advance_or_load,
	output var  logic        write_enable_n,
	output var  logic [3:0]  byte_lane_write_n,
	output var  logic [5:0]  address,
	output wire logic [31:0] data_in,
	output wire logic [3:0]  parity_in
);
	// ----------------------------------------
	// Shared line resolution
	// ----------------------------------------
	logic        drv_q = 1'b0;
	logic        pend_v = 1'b0;
	logic        late_v = 1'b0;
	logic        wr_burst = 1'b0;
	logic [35:0] pend = 36'h0;
	logic [35:0] late = 36'h0;
	logic [35:0] drv_val = 36'h0;
	logic [35:0] last_q = 36'h0;
	// Released lines toggle so a stale value can never pass as data
	wire  [35:0] bus = drv_q ? drv_val : (!data_oe_n ? {shared_parity_lines_out, data_out} : ~last_q);
	assign data_in = bus[31:0];
	assign parity_in = bus[35:32];
	always @(posedge sys_clk) last_q <= bus;

	initial
	begin
		clock_qualify_n = 1'b0;
		{chip_select_1_n, chip_select_2, chip_select_3_n} = 3'b101;
		{advance_or_load, write_enable_n, byte_lane_write_n, address} = 12'h3ff;
	end

	// One bus cycle; write data follows its command by two live calls,
	// so it stands at the second unstalled edge after the command
	task beat(input logic stall, input logic adv, input logic [2:0] m, input logic we_n,
		input logic [3:0] bw, input logic [5:0] a, input logic [35:0] wd);
		@(posedge sys_clk);
		#1;
		clock_qualify_n = stall;
		advance_or_load = adv;
		{chip_select_3_n, chip_select_2, chip_select_1_n} = m ^ 3'b101;
		write_enable_n = we_n;
		byte_lane_write_n = bw;
		address = a;
		if (!stall)
		begin
			drv_q = late_v;
			drv_val = late;
			late_v = pend_v;
			late = pend;
			if (!adv)
				wr_burst = (m == 3'b111) && !we_n;
			pend_v = wr_burst;
			pend = wd;
		end
	endtask
endmodule // host_bus_model
`default_nettype wire

//--- burst_sram_port_test.sv
// Self-checking testbench for the pipelined burst SRAM port
`timescale 1ns/10ps
`default_nettype none

module burst_sram_port_test;
	localparam AW = 6;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        output_drive_enable_n = 1'b0;
	logic        sleep_request = 1'b0;
	logic        burst_order_select = 1'b1;
	wire         clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n;
	wire         advance_or_load, write_enable_n, data_oe_n, shared_parity_lines_oe_n;
	wire         sleep_active;
	wire [3:0]   byte_lane_write_n, parity_in, shared_parity_lines_out;
	wire [AW-1:0] address;
	wire [31:0]  data_in, data_out;
	logic [35:0] mem [0:63];
	logic [35:0] exp_q [$];
	logic        act = 1'b0, wr = 1'b0, ord = 1'b1, stall_seen;
	logic [1:0]  k = 2'h0;
	logic [5:0]  base = 6'h00;
	logic [31:0] r;
	int          fails = 0, tests_run = 0, i, o, s;
	integer      seed = 32'h5e75_29a5;

	always #25 sys_clk = ~sys_clk;

	host_bus_model host (.sys_clk, .data_out, .data_oe_n, .shared_parity_lines_out,
		.clock_qualify_n, .chip_select_1_n, .chip_select_2, .chip_select_3_n, .advance_or_load,
		.write_enable_n, .byte_lane_write_n, .address, .data_in, .parity_in);
	burst_sram_port #(.LANES(4), .ADDR_W(AW)) dut (.sys_clk, .resetn, .clock_qualify_n,
		.chip_select_1_n, .chip_select_2, .chip_select_3_n, .advance_or_load, .write_enable_n,
		.byte_lane_write_n, .address, .output_drive_enable_n, .sleep_request,
		.burst_order_select, .data_in, .parity_in, .data_out, .data_oe_n,
		.shared_parity_lines_out, .shared_parity_lines_oe_n, .sleep_active);

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task check(input string what, input logic [35:0] e, input logic [35:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", what, e, g);
			fails++;
		end
	endtask

	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Stalled edges are skipped: the output stage is frozen there
	always @(posedge sys_clk)
	begin
		stall_seen = clock_qualify_n;
		#2;
		if (resetn === 1'b1 && stall_seen === 1'b0 && data_oe_n === 1'b0)
		begin
			if (exp_q.size() == 0)
				check("data_oe_n", 36'h1, {35'h0, data_oe_n});
			else
				check("read word", exp_q.pop_front(), {shared_parity_lines_out, data_out});
		end
	end

	// ----------------------------------------
	// Stimulus with reference memory
	// ----------------------------------------
	task op(input logic adv, input logic [2:0] m, input logic we_n, input logic [3:0] bw,
		input logic [5:0] a);
		logic [35:0] wd;
		logic [5:0]  ea;
		int          n;
		wd[31:0] = $random(seed);
		wd[35:32] = 4'($random(seed));
		if (!adv)
		begin
			act = (m == 3'b111);
			wr = !we_n;
			base = a;
			ord = burst_order_select;
			k = 2'h0;
		end
		else
			k = k + 2'h1;
		ea = {base[5:2], ord ? (base[1:0] ^ k) : (base[1:0] + k)};
		for (n = 0; n < 4; n++)
			if (act && wr && !bw[n])
			begin
				mem[ea][8*n +: 8] = wd[8*n +: 8];
				mem[ea][32+n] = wd[32+n];
			end
		if (act && !wr && !output_drive_enable_n)
			exp_q.push_back(mem[ea]);
		host.beat(1'b0, adv, m, we_n, bw, a, wd);
	endtask

	task idle(input int n);
		repeat (n) op(1'b0, 3'b000, 1'b1, 4'hf, 6'h00);
	endtask

	task wait_sleep(input logic v);
		int n;
		n = 0;
		while (sleep_active !== v && n < 20)
		begin
			@(posedge sys_clk);
			#2;
			n++;
		end
		check("sleep_active", {35'h0, v}, {35'h0, sleep_active});
		if (n >= 20)
			summarize();
	endtask

	initial
	begin
		repeat (12) @(posedge sys_clk);
		#1 resetn = 1'b1;
		idle(3);
		for (i = 0; i < 64; i++)
			op(1'b0, 3'b111, 1'b0, 4'h0, 6'(i));
		for (o = 0; o < 2; o++)
			for (s = 0; s < 4; s++)
			begin
				burst_order_select = o[0];
				idle(3);
				op(1'b0, 3'b111, 1'b1, 4'h0, {4'($random(seed)), 2'(s)});
				repeat (5) op(1'b1, 3'b000, 1'b0, 4'h0, 6'h3f);
				op(1'b0, 3'b111, 1'b0, 4'h0, {4'($random(seed)), 2'(s)});
				repeat (3) op(1'b1, 3'b000, 1'b1, 4'($random(seed)), 6'h00);
			end
		for (i = 0; i < 80; i++)
		begin
			r = $random(seed);
			case (r[1:0])
				2'd0: op(1'b0, 3'b111, 1'b1, r[7:4], r[13:8]);
				2'd1: op(1'b0, 3'b111, 1'b0, r[7:4], r[13:8]);
				2'd2: op(1'b0, r[16:14], r[2], r[7:4], r[13:8]);
				default: op(act, r[16:14], r[2], r[7:4], r[13:8]);
			endcase
		end
		output_drive_enable_n = 1'b1;
		idle(3);
		for (i = 0; i < 6; i++)
			op(i[0], 3'b111, 1'b1, 4'h0, 6'(i * 5));
		idle(3);
		output_drive_enable_n = 1'b0;
		idle(3);
		op(1'b0, 3'b111, 1'b1, 4'h0, 6'h21);
		host.beat(1'b1, 1'b0, 3'b111, 1'b0, 4'h0, 6'h3f, 36'h0);
		repeat (3) op(1'b1, 3'b000, 1'b0, 4'h0, 6'h00);
		idle(2);
		sleep_request = 1'b1;
		wait_sleep(1'b1);
		host.beat(1'b0, 1'b0, 3'b111, 1'b1, 4'h0, 6'h10, 36'h0);
		host.beat(1'b0, 1'b0, 3'b101, 1'b1, 4'h0, 6'h10, 36'h0);
		sleep_request = 1'b0;
		wait_sleep(1'b0);
		idle(3);
		op(1'b0, 3'b111, 1'b1, 4'h0, 6'h10);
		repeat (3) op(1'b1, 3'b000, 1'b0, 4'h0, 6'h00);
		idle(3);
		resetn = 1'b0;
		@(posedge sys_clk);
		#1 resetn = 1'b1;
		check("data_oe_n", 36'h1, {35'h0, data_oe_n});
		idle(3);
		op(1'b0, 3'b111, 1'b1, 4'h0, 6'h2a);
		idle(4);
		check("pending reads", 36'h0, 36'(exp_q.size()));
		summarize();
	end
endmodule // burst_sram_port_test
`default_nettype wire
